/* logic/cp_status_map.vh */
// register offsets, field positions and reset values of the protection status bank
`ifndef CP_STATUS_MAP_VH
`define CP_STATUS_MAP_VH
`define OFS_LINK_PROTECT_STATUS   8'hc4
`define OFS_KEY_FIFO_WRITE_DATA   8'hc9
`define OFS_KEY_FIFO_ADDR_LOW     8'hca
`define OFS_KEY_FIFO_ADDR_HIGH    8'hcb
`define OFS_REPEATER_PORT0_DESC   8'he0
`define OFS_REPEATER_PORT1_DESC   8'he1
`define OFS_REPEATER_PORT2_DESC   8'he2
`define OFS_REPEATER_PORT3_DESC   8'he3
`define OFS_IDENT_BYTE0           8'hf0
`define BIT_AUTH_DONE_FLAG        0
`define BIT_LINE_SUM_MISMATCH     1
`define BIT_PORT_PRESENT          0
`define RST_REG8                  8'h00
`define RST_KEY_ADDR              9'h000
`define KEY_ADDR_WIDTH            9
`endif

/* logic/sticky_flag.v */
// one sticky status flag: hardware set beats clear
`timescale 1ns/10ps
module sticky_flag (
	// clock and reset
	input  wire i_clk,
	input  wire i_sys_rst,
	// control
	input  wire i_set,
	input  wire i_clr,
	// state
	output reg  o_flag_q
);
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_flag_q <= 1'b0;
		end else if (i_set) begin
			o_flag_q <= 1'b1;
		end else if (i_clr) begin
			o_flag_q <= 1'b0;
		end
	end
endmodule // sticky_flag

/* logic/content_protect_status_key_fifo_regs.v */
// status, key fifo load port, repeater port descriptors and identification byte
// Notes on behaviour
// - set bit 1 on line checksum mismatch
// - a status write clears checksum error, unless a mismatch arrives in the same cycle
// - set bit 0 when authentication succeeds
// - clear auth flag on loss or restart
// - each data write stores byte at address
// - address increments after each data write
// - low address byte at first register
// - address msb in second register
// - port registers give address in 7:1
// - port bit 0 flags port present
// - identification byte read only, writes ignored
`timescale 1ns/10ps
`include "cp_status_map.vh"
module content_protect_status_key_fifo_regs #(
	parameter [7:0] IDENT_BYTE0 = 8'h00 // arbitrary value
) (
	// clock and reset
	input  wire       i_clk,
	input  wire       i_sys_rst,
	// register access from the serial control bus engine (same clock)
	input  wire       i_reg_wr,
	input  wire       i_reg_rd,
	input  wire [7:0] i_reg_addr,
	input  wire [7:0] i_reg_wdata,
	output reg  [7:0] o_reg_rdata_q,
	output reg        o_reg_hit_q,
	// protection engine events (same clock)
	input  wire       i_line_sum_enabled,
	input  wire       i_line_sum_mismatch,
	input  wire       i_auth_success,
	input  wire       i_auth_lost,
	input  wire       i_auth_restart,
	// repeater transmit port descriptors, from strapping or engine
	input  wire [6:0] i_port0_bus_address,
	input  wire [6:0] i_port1_bus_address,
	input  wire [6:0] i_port2_bus_address,
	input  wire [6:0] i_port3_bus_address,
	input  wire [3:0] i_port_present,
	// key fifo write port
	output reg        o_key_fifo_we_q,
	output reg  [8:0] o_key_fifo_addr_q,
	output reg  [7:0] o_key_fifo_data_q
);
	wire       wr_status;
	wire       wr_data;
	wire       wr_low;
	wire       wr_high;
	wire       line_sum_err;
	reg        auth_q;
	reg  [8:0] key_addr_q;
	reg  [8:0] key_addr_d;
	reg  [7:0] data_q;
	reg  [7:0] rdata_d;
	reg        hit_d;

	assign wr_status = i_reg_wr && (i_reg_addr == `OFS_LINK_PROTECT_STATUS);
	assign wr_data   = i_reg_wr && (i_reg_addr == `OFS_KEY_FIFO_WRITE_DATA);
	assign wr_low    = i_reg_wr && (i_reg_addr == `OFS_KEY_FIFO_ADDR_LOW);
	assign wr_high   = i_reg_wr && (i_reg_addr == `OFS_KEY_FIFO_ADDR_HIGH);

	// a mismatch in the same cycle as the clearing write is kept
	sticky_flag u_line_sum_mismatch (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_set     (i_line_sum_enabled && i_line_sum_mismatch),
		.i_clr     (wr_status),
		.o_flag_q  (line_sum_err)
	);

	// loss or restart wins: a stale success must not reopen protected video
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			auth_q <= 1'b0;
		end else if (i_auth_lost || i_auth_restart) begin
			auth_q <= 1'b0;
		end else if (i_auth_success) begin
			auth_q <= 1'b1;
		end
	end

	always @* begin
		key_addr_d = key_addr_q;
		if (wr_low) begin
			key_addr_d[7:0] = i_reg_wdata;
		end
		if (wr_high) begin
			key_addr_d[8] = i_reg_wdata[0];
		end
		if (wr_data) begin
			key_addr_d = key_addr_q + 9'h001;
		end
	end

	// key fifo address and readback byte
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			key_addr_q <= `RST_KEY_ADDR;
		end else begin
			key_addr_q <= key_addr_d;
		end
	end

	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			data_q <= `RST_REG8;
		end else if (wr_data) begin
			data_q <= i_reg_wdata;
		end
	end

	// the port carries the address before the step, so the byte lands where the
	// controller aimed it
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_key_fifo_we_q <= 1'b0;
		end else begin
			o_key_fifo_we_q <= wr_data;
		end
	end

	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_key_fifo_addr_q <= `RST_KEY_ADDR;
		end else if (wr_data) begin
			o_key_fifo_addr_q <= key_addr_q;
		end
	end

	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_key_fifo_data_q <= `RST_REG8;
		end else if (wr_data) begin
			o_key_fifo_data_q <= i_reg_wdata;
		end
	end

	// status and key fifo views
	reg  [7:0] status_view;
	wire [7:0] data_view;
	wire [7:0] addr_low_view;
	wire [7:0] addr_high_view;

	// repeater port descriptors: address above, present flag in bit 0
	wire [7:0] port0_view;
	wire [7:0] port1_view;
	wire [7:0] port2_view;
	wire [7:0] port3_view;

	// identification byte, fixed by parameter so writes can never reach it
	wire [7:0] ident_view;

	always @* begin
		status_view                         = `RST_REG8;
		status_view[`BIT_AUTH_DONE_FLAG]    = auth_q;
		status_view[`BIT_LINE_SUM_MISMATCH] = line_sum_err;
	end

	assign data_view      = data_q;
	assign addr_low_view  = key_addr_q[7:0];
	assign addr_high_view = {7'h00, key_addr_q[8]};

	assign port0_view     = {i_port0_bus_address, i_port_present[0]};
	assign port1_view     = {i_port1_bus_address, i_port_present[1]};
	assign port2_view     = {i_port2_bus_address, i_port_present[2]};
	assign port3_view     = {i_port3_bus_address, i_port_present[3]};

	assign ident_view     = IDENT_BYTE0;

	always @* begin
		rdata_d = `RST_REG8;
		hit_d   = 1'b1;
		case (i_reg_addr)
			`OFS_LINK_PROTECT_STATUS: begin
				rdata_d = status_view;
			end
			`OFS_KEY_FIFO_WRITE_DATA: begin
				rdata_d = data_view;
			end
			`OFS_KEY_FIFO_ADDR_LOW: begin
				rdata_d = addr_low_view;
			end
			`OFS_KEY_FIFO_ADDR_HIGH: begin
				rdata_d = addr_high_view;
			end
			`OFS_REPEATER_PORT0_DESC: begin
				rdata_d = port0_view;
			end
			`OFS_REPEATER_PORT1_DESC: begin
				rdata_d = port1_view;
			end
			`OFS_REPEATER_PORT2_DESC: begin
				rdata_d = port2_view;
			end
			`OFS_REPEATER_PORT3_DESC: begin
				rdata_d = port3_view;
			end
			`OFS_IDENT_BYTE0: begin
				rdata_d = ident_view;
			end
			default: begin
				hit_d = 1'b0;
			end
		endcase
	end

	// read data holds until the next read so a slow bus engine can pick it up late
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_reg_rdata_q <= `RST_REG8;
		end else if (i_reg_rd) begin
			o_reg_rdata_q <= rdata_d;
		end
	end

	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_reg_hit_q <= 1'b0;
		end else if (i_reg_rd) begin
			o_reg_hit_q <= hit_d;
		end
	end
endmodule // content_protect_status_key_fifo_regs

/* verification/cp_regs_sva.sv */
// port checker for the protection status bank
`timescale 1ns/10ps
module cp_regs_sva (
	input wire       i_clk, i_sys_rst, i_reg_wr, i_reg_rd, o_reg_hit_q, o_key_fifo_we_q,
	input wire       i_line_sum_enabled, i_line_sum_mismatch,
	input wire [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata_q, o_key_fifo_data_q,
	input wire [8:0] o_key_fifo_addr_q
);
	wire       bad = i_line_sum_enabled && i_line_sum_mismatch;
	wire       rd  = i_reg_rd;
	wire       dw  = i_reg_wr && i_reg_addr == 8'hc9;
	wire       wc  = i_reg_wr && i_reg_addr == 8'hc4;
	wire [7:0] a   = i_reg_addr;
	wire [7:0] q   = o_reg_rdata_q;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	sequence s_two; dw ##1 dw; endsequence
	property p_we; dw |=> o_key_fifo_we_q && o_key_fifo_data_q == $past(i_reg_wdata); endproperty
	a_we: assert property (p_we) else $error("byte lost");
	property p_nowe; !dw |=> !o_key_fifo_we_q; endproperty
	a_nowe: assert property (p_nowe) else $error("stray write");
	property p_inc; s_two |=> o_key_fifo_addr_q == $past(o_key_fifo_addr_q) + 9'h001; endproperty
	a_inc: assert property (p_inc) else $error("no step");
	property p_lo; rd && a == 8'hca |=> o_reg_hit_q; endproperty
	a_lo: assert property (p_lo) else $error("low miss");
	property p_hi; rd && a == 8'hcb |=> q[7:1] == 7'h00; endproperty
	a_hi: assert property (p_hi) else $error("high bad");
	property p_port; rd && a[7:2] == 6'h38 |=> o_reg_hit_q; endproperty
	a_port: assert property (p_port) else $error("port miss");
	property p_sum; bad ##1 !wc ##1 rd && a == 8'hc4 |=> q[1]; endproperty
	a_sum: assert property (p_sum) else $error("sum lost");
	property p_clr; wc && !bad ##1 rd && a == 8'hc4 |=> !q[1]; endproperty
	a_clr: assert property (p_clr) else $error("no clear");
endmodule // cp_regs_sva
bind content_protect_status_key_fifo_regs cp_regs_sva u_cp_regs_sva (.*);

/* verification/ctl.sv */
// controller model issuing register accesses
`timescale 1ns/10ps
module ctl (
	input  wire       i_clk,
	output reg        o_wr = 0,
	output reg        o_rd = 0,
	output reg  [7:0] o_addr = 8'h00,
	output reg  [7:0] o_wdata = 8'h00
);
	// one access per cycle; idle lines toggle so stale values are never trusted
	task acc(input logic w, r, input logic [7:0] a, d);
		@(negedge i_clk);
		{o_wr, o_rd} = {w, r};
		{o_addr, o_wdata} = (w | r) ? {a, d} : ~{o_addr, o_wdata};
	endtask
endmodule // ctl

/* verification/tb.sv */
// bench for the protection status bank
`timescale 1ns/10ps
module tb;
	logic        i_clk = 0, i_sys_rst = 1;
	logic [4:0]  ev = 5'h00;
	logic [3:0]  present = 4'h5;
	wire         i_reg_wr, i_reg_rd, o_reg_hit_q, o_key_fifo_we_q;
	wire  [7:0]  i_reg_addr, i_reg_wdata, o_reg_rdata_q, o_key_fifo_data_q;
	wire  [8:0]  o_key_fifo_addr_q;
	wire  [17:0] fifo = {o_key_fifo_we_q, o_key_fifo_addr_q, o_key_fifo_data_q};
	int          errors = 0, compares = 0;
	// {events, write first, offset, hit, data}
	logic [22:0] rows [17] = '{23'h01_c125, 23'h01_c368, 23'h01_c5ad, 23'h01_c7fe, 23'h03_e1a7,
		23'h03_c125, 23'h01_9300, 23'h01_9500, 23'h01_9700, 23'h00_a000, 23'h21_8900,
		23'h61_8902, 23'h03_8900, 23'h11_8901, 23'h09_8900, 23'h11_8901, 23'h05_8900};
	initial forever #20 i_clk = ~i_clk;
	ctl u_ctl (.i_clk(i_clk), .o_wr(i_reg_wr), .o_rd(i_reg_rd), .o_addr(i_reg_addr),
		.o_wdata(i_reg_wdata));
	content_protect_status_key_fifo_regs #(.IDENT_BYTE0(8'ha7)) // arbitrary ident value
		u_content_protect_status_key_fifo_regs (.i_line_sum_enabled(ev[4]),
		.i_line_sum_mismatch(ev[3]), .i_auth_success(ev[2]), .i_auth_lost(ev[1]),
		.i_auth_restart(ev[0]), .i_port0_bus_address(7'h12), .i_port1_bus_address(7'h34),
		.i_port2_bus_address(7'h56), .i_port3_bus_address(7'h7f), .i_port_present(present), .*);
	task chk(input logic [17:0] s, e);
		compares++;
		errors += (s !== e);
		if (s !== e) $display("FAIL %0t seen %h expected %h", $time, s, e);
	endtask
	task print_verdict;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (6) @(negedge i_clk);
		i_sys_rst = 0;
		for (int k = 0; k < 17; k++) begin
			ev = rows[k][22:18];
			u_ctl.acc(rows[k][17], 1'b0, rows[k][16:9], 8'h5a);
			ev = 5'h00;
			u_ctl.acc(1'b0, 1'b1, rows[k][16:9], 8'h00);
			u_ctl.acc(1'b0, 1'b0, 8'h00, 8'h00);
			chk({o_reg_hit_q, o_reg_rdata_q}, rows[k][8:0]);
		end
		$display("table test done");
		u_ctl.acc(1'b1, 1'b0, 8'hcb, 8'h01);
		u_ctl.acc(1'b1, 1'b0, 8'hca, 8'hff);
		u_ctl.acc(1'b1, 1'b0, 8'hc9, 8'haa);
		u_ctl.acc(1'b1, 1'b0, 8'hc9, 8'hbb);
		chk(fifo, 18'h3_ffaa);
		u_ctl.acc(1'b0, 1'b1, 8'hca, 8'h00);
		chk(fifo, 18'h2_00bb);
		u_ctl.acc(1'b1, 1'b0, 8'hca, 8'h00);
		chk({o_reg_hit_q, o_reg_rdata_q}, 9'h101);
		$display("fifo test done");
		present = 4'ha;
		u_ctl.acc(1'b0, 1'b1, 8'he1, 8'h00);
		u_ctl.acc(1'b0, 1'b1, 8'hc9, 8'h00);
		chk({o_reg_hit_q, o_reg_rdata_q}, 9'h169);
		u_ctl.acc(1'b0, 1'b0, 8'h00, 8'h00);
		chk({o_reg_hit_q, o_reg_rdata_q}, 9'h1bb);
		i_sys_rst = 1;
		repeat (2) @(negedge i_clk);
		chk({o_reg_hit_q, o_reg_rdata_q}, 9'h000);
		chk(fifo, 18'h0_0000);
		i_sys_rst = 0;
		u_ctl.acc(1'b0, 1'b1, 8'hca, 8'h00);
		u_ctl.acc(1'b0, 1'b0, 8'h00, 8'h00);
		chk({o_reg_hit_q, o_reg_rdata_q}, 9'h100);
		$display("reset test done");
		print_verdict;
	end
	initial begin
		#20000 errors++;
		print_verdict;
	end
endmodule // tb
